// ==== wdw_asserts.sv ====
// assertions on the watchdog top ports
// assumes bind into wdw_top, one clock, sync reset
`timescale 1ns/10ps
module wdw_asserts
  import wdw_pkg::*;
#(
  parameter logic [7:0] CFG_INIT = CFG_RESET
) (
  input wire logic                       CLOCK,
  input wire logic                       SYS_RST,
  input wire logic [wdw_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic [wdw_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [wdw_pkg::DATA_W-1:0] AVS_READDATA,
  input wire logic                       AVS_WAITREQUEST,
  input wire logic                       OSC_ENABLE,
  input wire logic                       WDOG_RESET,
  input wire logic                       CORE_WAKE,
  input wire logic                       IRQ
);
  logic       hw_q;
  logic [1:0] hw_cnt_q;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  // hardware enable as last written over the bus
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      hw_q <= CFG_INIT[CFG_HWEN_BIT];
    end else if (AVS_WRITE && !AVS_WAITREQUEST &&
                 AVS_ADDRESS == OFS_CONFIG) begin
      hw_q <= AVS_WRITEDATA[CFG_HWEN_BIT];
    end
  end

  // cycles the hardware enable has stood, saturating
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !hw_q) begin
      hw_cnt_q <= 2'h0;
    end else if (hw_cnt_q != 2'h3) begin
      hw_cnt_q <= hw_cnt_q + 2'h1;
    end
  end

  // bus handshake: one wait cycle, one answer cycle
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS > 8'h14 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  // watchdog outputs
  a_reset_pulse: assert property (WDOG_RESET |=> !WDOG_RESET)
    else $error("reset pulse longer than one cycle");
  a_wake_pulse: assert property (CORE_WAKE |=> !CORE_WAKE)
    else $error("wake pulse longer than one cycle");
  a_reset_cause: assert property ($rose(WDOG_RESET) |->
    $past(OSC_ENABLE)) else $error("reset while watchdog off");
  a_wake_cause: assert property (CORE_WAKE |-> $past(OSC_ENABLE))
    else $error("wake while watchdog off");
  a_hw_force: assert property (hw_cnt_q == 2'h3 |-> OSC_ENABLE)
    else $error("hardware enable not forcing oscillator");

  c_reset: cover property (WDOG_RESET);
  c_wake: cover property (CORE_WAKE);
  c_irq: cover property ($rose(IRQ));
endmodule : wdw_asserts

bind wdw_top wdw_asserts #(.CFG_INIT(CFG_INIT)) u_chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .OSC_ENABLE(OSC_ENABLE),
  .WDOG_RESET(WDOG_RESET), .CORE_WAKE(CORE_WAKE), .IRQ(IRQ));

// ==== wdw_count.sv ====
// prescaler, postscaler and window detect of the watchdog
// assumes one oscillator tick pulse per low-power rc period
`timescale 1ns/10ps
module wdw_count
  import wdw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       pre_long,
  input  wire logic [3:0] post,
  output logic            timeout_q,
  output logic            in_window_q
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] win_start;

  // full period and start of the final quarter
  always_comb begin
    period    = wdw_period(pre_long, post);
    win_start = period - (period >> 2);
  end

  // one count for prescaler and postscaler together
  always_ff @(posedge clk) begin
    if (rst || clr || !run) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q == period - CNT_W'(1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // time-out pulse on the last tick of the period
  always_ff @(posedge clk) begin
    if (rst || clr || !run) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= tick && (cnt_q == period - CNT_W'(1));
    end
  end

  // clear is allowed once the count reaches the final quarter
  always_ff @(posedge clk) begin
    if (rst || clr || !run) begin
      in_window_q <= 1'b0;
    end else begin
      in_window_q <= (cnt_q >= win_start);
    end
  end

endmodule : wdw_count

// ==== wdw_pkg.sv ====
// package of the windowed watchdog: register map, field layout, timing
// assumes a 32-bit avalon-mm slave, byte addresses, one word per register
package wdw_pkg;

  // clock and oscillator timing
  localparam int unsigned CLK_FREQ_HZ   = 200_000_000;
  localparam int unsigned LOW_POWER_RC_OSC_FREQ_HZ  = 32_000;
  localparam int unsigned LOW_POWER_RC_OSC_DIV_CYC  = CLK_FREQ_HZ / LOW_POWER_RC_OSC_FREQ_HZ;
  localparam int unsigned PRE_SHORT_MS  = 1;   // nominal, divide by 32
  localparam int unsigned PRE_LONG_MS   = 4;   // nominal, divide by 128
  localparam int unsigned PRE_SHORT_DIV =
    (PRE_SHORT_MS * LOW_POWER_RC_OSC_FREQ_HZ) / 1000;
  localparam int unsigned PRE_LONG_DIV  =
    (PRE_LONG_MS * LOW_POWER_RC_OSC_FREQ_HZ) / 1000;
  localparam int unsigned PRE_SHORT_LOG = 5;
  localparam int unsigned PRE_LONG_LOG  = 7;

  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RCTRL  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  // configuration word fields
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_POST_W   = 4;
  localparam int unsigned CFG_PRE_BIT  = 4;
  localparam int unsigned CFG_PLLK_BIT = 5;
  localparam int unsigned CFG_WDIS_BIT = 6;
  localparam int unsigned CFG_HWEN_BIT = 7;
  localparam logic [7:0]  CFG_RESET    = 8'h7F;

  // reset control register fields
  localparam int unsigned RC_IDLE_BIT  = 2;
  localparam int unsigned RC_SLEEP_BIT = 3;
  localparam int unsigned RC_TO_BIT    = 4;
  localparam int unsigned RC_SWEN_BIT  = 5;

  // interrupt status and mask fields
  localparam int unsigned ST_W       = 3;
  localparam int unsigned ST_TIMEOUT = 0;
  localparam int unsigned ST_EARLY   = 1;
  localparam int unsigned ST_WAKE    = 2;

  // command register fields
  localparam int unsigned CMD_CLR   = 0;
  localparam int unsigned CMD_SLEEP = 1;
  localparam int unsigned CMD_IDLE  = 2;

  // state register fields and configuration word width
  localparam int unsigned CFG_W          = 8;
  localparam int unsigned STATE_MODE_LSB = 0;
  localparam int unsigned STATE_MODE_W   = 2;
  localparam int unsigned STATE_WIN_BIT  = 2;
  localparam int unsigned STATE_ON_BIT   = 3;

  // counter geometry: 128 * 32768 oscillator ticks at most
  localparam int unsigned CNT_W = 23;

  typedef enum logic [1:0] {
    WDW_RUN   = 2'b00,
    WDW_SLEEP = 2'b01,
    WDW_IDLE  = 2'b10
  } wdw_mode_t;

  // oscillator ticks in one full watchdog period
  function automatic logic [CNT_W-1:0] wdw_period(
    input logic       pre_long,
    input logic [3:0] post
  );
    logic [CNT_W-1:0] base;
    base = pre_long ? CNT_W'(PRE_LONG_DIV) : CNT_W'(PRE_SHORT_DIV);
    return base << post;
  endfunction : wdw_period

endpackage : wdw_pkg

// ==== wdw_tb_top.sv ====
// self-checking bench of the windowed watchdog
// assumes a short oscillator divide so periods stay brief
`timescale 1ns/10ps
module wdw_tb_top;
  import wdw_pkg::*;
  localparam int         OD = 4;
  localparam logic [7:0] CI = 8'h40;
  typedef struct { logic [7:0] cfg; int tk; } wdw_row_t;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, csw = 0, wreq = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        wait_r, osc, wrst, wake, irq;
  int          n_fail = 0, check_count = 0, cyc = 0, n_rst = 0;
  int          n_wake = 0, t0, i, k, nr, nw;
  wdw_row_t    rows [5] = '{'{8'h40, 32}, '{8'h50, 128},
                            '{8'h41, 64}, '{8'h43, 256}, '{8'h52, 512}};

  wdw_top #(.OSC_DIV(OD), .CFG_INIT(CI)) dut (
    .CLOCK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_r), .CLK_SWITCH_DONE(csw), .WAKE_REQ(wreq),
    .OSC_ENABLE(osc), .WDOG_RESET(wrst), .CORE_WAKE(wake), .IRQ(irq));

  always #2.5 clk = ~clk;
  // cycle count and pulse tallies
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wrst === 1'b1) n_rst <= n_rst + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
  end

  task report_and_stop;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // one avalon transfer, read data left in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (j = 0; j < 20; j++) begin
      @(posedge clk);
      if (wait_r === 1'b0) break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (j == 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask : bus

  // wait for a reset or wake pulse after the snapshot
  task wait_ev(input int lim);
    int j;
    for (j = 0; j < lim; j++) begin
      @(posedge clk);
      if (n_rst != nr || n_wake != nw) break;
    end
    if (j == lim) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_ev

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("config", {24'h0, CI}, q);
    bus(1'b0, OFS_RCTRL, 32'h0);
    chk("rctrl", 32'h0, q);
    chk("osc", 32'h0, osc);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_MASK, 32'h1);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, OFS_CONFIG, {24'h0, rows[i].cfg});
      nr = n_rst;
      nw = n_wake;
      bus(1'b1, OFS_RCTRL, 32'h20);
      t0 = cyc;
      repeat (2) @(posedge clk);
      chk("osc on", 32'h1, osc);
      wait_ev(5000);
      k = OD * rows[i].tk;
      chk_rng("period", k - OD, k + OD + 4, cyc - t0);
      bus(1'b0, OFS_RCTRL, 32'h0);
      chk("to flag", 32'h10, q);
      chk("irq set", 32'h1, irq);
      bus(1'b1, OFS_STATUS, 32'h7);
      @(posedge clk);
      chk("irq clr", 32'h0, irq);
    end
    // early clear in window mode
    bus(1'b1, OFS_CONFIG, 32'h0);
    nr = n_rst;
    nw = n_wake;
    bus(1'b1, OFS_RCTRL, 32'h20);
    bus(1'b1, OFS_CMD, 32'h1);
    wait_ev(10);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("early", 32'h2, q & 32'h2);
    bus(1'b1, OFS_STATUS, 32'h7);
    // late clear inside the final quarter
    nr = n_rst;
    bus(1'b1, OFS_RCTRL, 32'h20);
    repeat (108) @(posedge clk);
    bus(1'b1, OFS_CMD, 32'h1);
    repeat (20) @(posedge clk);
    chk("late clr", nr, n_rst);
    // clears and clock switches keep it alive
    bus(1'b1, OFS_CONFIG, 32'h40);
    for (k = 0; k < 6; k++) begin
      repeat (80) @(posedge clk);
      if (k[0]) begin
        csw <= 1'b1;
        @(posedge clk);
        csw <= 1'b0;
      end else bus(1'b1, OFS_CMD, 32'h1);
    end
    chk("kept", nr, n_rst);
    // sleep, wake by time-out, then idle left by wake request
    nw = n_wake;
    bus(1'b1, OFS_CMD, 32'h2);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("sleep", 32'h1, q & 32'h3);
    wait_ev(300);
    chk("no rst", nr, n_rst);
    bus(1'b0, OFS_RCTRL, 32'h0);
    chk("slp flag", 32'h38, q);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("wake st", 32'h4, q & 32'h4);
    bus(1'b1, OFS_RCTRL, 32'h20);
    bus(1'b0, OFS_RCTRL, 32'h0);
    chk("flag clr", 32'h20, q);
    bus(1'b1, OFS_CMD, 32'h4);
    bus(1'b0, OFS_STATE, 32'h0);
    chk("idle", 32'h2, q & 32'h3);
    wreq <= 1'b1;
    repeat (3) @(posedge clk);
    wreq <= 1'b0;
    bus(1'b0, OFS_STATE, 32'h0);
    chk("run", 32'h0, q & 32'h3);
    bus(1'b0, OFS_RCTRL, 32'h0);
    chk("idl flag", 32'h24, q);
    // hardware enable overrides software
    bus(1'b1, OFS_CONFIG, 32'hC0);
    bus(1'b1, OFS_RCTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("hw on", 32'h1, osc);
    bus(1'b1, OFS_CONFIG, 32'h40);
    repeat (2) @(posedge clk);
    chk("hw off", 32'h0, osc);
    // reset in mid-run clears software enable
    bus(1'b1, OFS_RCTRL, 32'h20);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_RCTRL, 32'h0);
    chk("rst swen", 32'h0, q);
    report_and_stop();
  end
endmodule : wdw_tb_top

// ==== wdw_top.sv ====
// windowed watchdog with avalon-mm register access
// assumes CLOCK is the core clock; oscillator ticks are derived from it
//
// How it works
// - watchdog counts low-power oscillator; enabling starts it
// - prescale select one divides 128, zero 32
// - postscale code n gives ratio two to n
// - prescaler period about 1 ms or 4 ms
// - device reset or clock switch clears counters
// - power-save entry and exit clear counters
// - clear instruction resets counter and scalers
// - keeps counting asleep; time-out wakes core
// - time-out flag set and held until cleared
// - hardware enable forces watchdog and oscillator on
// - software enable bit controls otherwise; reset clears
// - window mode: early clear causes watchdog reset
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module wdw_top
  import wdw_pkg::*;
#(
  parameter int unsigned   OSC_DIV    = LOW_POWER_RC_OSC_DIV_CYC,
  parameter logic [7:0]    CFG_INIT   = CFG_RESET
) (
  input  wire logic                      CLOCK,
  input  wire logic                      SYS_RST,
  input  wire logic [wdw_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [wdw_pkg::DATA_W-1:0] AVS_WRITEDATA,
  output logic      [wdw_pkg::DATA_W-1:0] AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  input  wire logic                      CLK_SWITCH_DONE,
  input  wire logic                      WAKE_REQ,
  output logic                           OSC_ENABLE,
  output logic                           WDOG_RESET,
  output logic                           CORE_WAKE,
  output logic                           IRQ
);

  import wdw_pkg::*;

  // refuse settings the divider cannot serve
  if (OSC_DIV < 2) begin : g_chk_div
    $error("OSC_DIV must be at least 2");
  end

  localparam int unsigned DIV_W = $clog2(OSC_DIV);

  logic [7:0]       cfg_q;
  logic             sw_en_q;
  logic             sleep_flag_q;
  logic             idle_flag_q;
  logic             to_flag_q;
  logic [ST_W-1:0]  status_q;
  logic [ST_W-1:0]  mask_q;
  wdw_mode_t        mode_q;
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  logic             wd_rst_q;
  logic             wake_q;
  logic             wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic             irq_q;

  logic             hw_en;
  logic             wd_on;
  logic             pre_long;
  logic [3:0]       post;
  logic             win_dis;
  logic             acc;
  logic             wr_cfg;
  logic             wr_rc;
  logic             wr_st;
  logic             wr_mask;
  logic             wr_cmd;
  logic             cmd_clr;
  logic             cmd_sleep;
  logic             cmd_idle;
  logic             in_run;
  logic             early_clr;
  logic             good_clr;
  logic             enter_ps;
  logic             exit_ps;
  logic             timeout;
  logic             in_window;
  logic             run_to;
  logic             ps_to;
  logic             dev_rst;
  logic             cnt_clr;
  logic [ST_W-1:0]  st_set;

  // configuration fields
  assign hw_en    = cfg_q[CFG_HWEN_BIT];
  assign pre_long = cfg_q[CFG_PRE_BIT];
  assign post     = cfg_q[CFG_POST_LSB +: CFG_POST_W];
  assign win_dis  = cfg_q[CFG_WDIS_BIT];
  assign wd_on    = hw_en || sw_en_q;

  // bus request taken at the edge where waitrequest is low
  assign acc     = !wait_q;
  assign wr_cfg  = acc && AVS_WRITE && (AVS_ADDRESS == OFS_CONFIG);
  assign wr_rc   = acc && AVS_WRITE && (AVS_ADDRESS == OFS_RCTRL);
  assign wr_st   = acc && AVS_WRITE && (AVS_ADDRESS == OFS_STATUS);
  assign wr_mask = acc && AVS_WRITE && (AVS_ADDRESS == OFS_MASK);
  assign wr_cmd  = acc && AVS_WRITE && (AVS_ADDRESS == OFS_CMD);

  // commands standing for the core's instructions
  assign in_run    = (mode_q == WDW_RUN);
  assign cmd_clr   = wr_cmd && AVS_WRITEDATA[CMD_CLR] && in_run;
  assign cmd_sleep = wr_cmd && AVS_WRITEDATA[CMD_SLEEP] && in_run;
  assign cmd_idle  = wr_cmd && AVS_WRITEDATA[CMD_IDLE] && in_run
                     && !AVS_WRITEDATA[CMD_SLEEP];
  assign enter_ps  = cmd_sleep || cmd_idle;

  // window check on the clear instruction
  assign early_clr = cmd_clr && wd_on && !win_dis && !in_window;
  assign good_clr  = cmd_clr && !early_clr;

  // time-out split by power mode
  assign run_to  = timeout && in_run;
  assign ps_to   = timeout && !in_run;
  assign exit_ps = !in_run && (ps_to || WAKE_REQ);
  assign dev_rst = SYS_RST || wd_rst_q;

  // every event that restarts the count
  assign cnt_clr = dev_rst || CLK_SWITCH_DONE
                   || enter_ps || exit_ps
                   || good_clr;

  // hardware events for the sticky status
  always_comb begin
    st_set             = '0;
    st_set[ST_TIMEOUT] = timeout;
    st_set[ST_EARLY]   = early_clr;
    st_set[ST_WAKE]    = ps_to;
  end

  // configuration word, software written
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cfg_q <= CFG_INIT;
    end else if (wr_cfg) begin
      cfg_q <= AVS_WRITEDATA[CFG_W-1:0];
    end
  end

  // software enable, cleared by every device reset
  always_ff @(posedge CLOCK) begin
    if (dev_rst) begin
      sw_en_q <= 1'b0;
    end else if (wr_rc) begin
      sw_en_q <= AVS_WRITEDATA[RC_SWEN_BIT];
    end
  end

  // time-out flag: set wins, only software clears
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      to_flag_q <= 1'b0;
    end else if (timeout) begin
      to_flag_q <= 1'b1;
    end else if (wr_rc) begin
      to_flag_q <= to_flag_q && AVS_WRITEDATA[RC_TO_BIT];
    end
  end

  // sleep and idle flags: hardware sets, software clears
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sleep_flag_q <= 1'b0;
      idle_flag_q  <= 1'b0;
    end else begin
      if (cmd_sleep) begin
        sleep_flag_q <= 1'b1;
      end else if (wr_rc) begin
        sleep_flag_q <= sleep_flag_q && AVS_WRITEDATA[RC_SLEEP_BIT];
      end
      if (cmd_idle) begin
        idle_flag_q <= 1'b1;
      end else if (wr_rc) begin
        idle_flag_q <= idle_flag_q && AVS_WRITEDATA[RC_IDLE_BIT];
      end
    end
  end

  // power mode: entered by command, left on wake
  always_ff @(posedge CLOCK) begin
    if (dev_rst) begin
      mode_q <= WDW_RUN;
    end else begin
      case (mode_q)
        WDW_RUN: begin
          if (cmd_sleep) begin
            mode_q <= WDW_SLEEP;
          end else if (cmd_idle) begin
            mode_q <= WDW_IDLE;
          end
        end
        WDW_SLEEP, WDW_IDLE: begin
          if (exit_ps) begin
            mode_q <= WDW_RUN;
          end
        end
        default: mode_q <= WDW_RUN;
      endcase
    end
  end

  // low-power oscillator model: one tick per rc period
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !wd_on) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(OSC_DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // oscillator runs whenever the watchdog is on
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OSC_ENABLE <= 1'b0;
    end else begin
      OSC_ENABLE <= wd_on;
    end
  end

  // prescaler, postscaler and window
  wdw_count u_count (
    .clk         (CLOCK),
    .rst         (SYS_RST),
    .clr         (cnt_clr),
    .run         (wd_on),
    .tick        (tick_q),
    .pre_long    (pre_long),
    .post        (post),
    .timeout_q   (timeout),
    .in_window_q (in_window)
  );

  // watchdog reset pulse on running time-out or early clear
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wd_rst_q <= 1'b0;
    end else begin
      wd_rst_q <= run_to || early_clr;
    end
  end

  // wake pulse when a time-out ends power save
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ps_to;
    end
  end

  assign WDOG_RESET = wd_rst_q;
  assign CORE_WAKE  = wake_q;

  // sticky status, write one to clear, set wins
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      status_q <= '0;
    end else if (wr_st) begin
      status_q <= (status_q & ~AVS_WRITEDATA[ST_W-1:0]) | st_set;
    end else begin
      status_q <= status_q | st_set;
    end
  end

  // interrupt mask
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= AVS_WRITEDATA[ST_W-1:0];
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign IRQ = irq_q;

  // waitrequest drops for one cycle per request
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
    end
  end

  assign AVS_WAITREQUEST = wait_q;

  // read data captured as waitrequest drops
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (AVS_READ && wait_q) begin
      rdata_q <= '0;
      case (AVS_ADDRESS)
        OFS_CONFIG: rdata_q[CFG_W-1:0] <= cfg_q;
        OFS_RCTRL: begin
          rdata_q[RC_IDLE_BIT]  <= idle_flag_q;
          rdata_q[RC_SLEEP_BIT] <= sleep_flag_q;
          rdata_q[RC_TO_BIT]    <= to_flag_q;
          rdata_q[RC_SWEN_BIT]  <= sw_en_q;
        end
        OFS_STATUS: rdata_q[ST_W-1:0] <= status_q;
        OFS_MASK:   rdata_q[ST_W-1:0] <= mask_q;
        OFS_STATE: begin
          rdata_q[STATE_MODE_LSB +: STATE_MODE_W] <= mode_q;
          rdata_q[STATE_WIN_BIT] <= in_window;
          rdata_q[STATE_ON_BIT]  <= wd_on;
        end
        default: rdata_q <= '0;                      // unmapped reads zero
      endcase
    end
  end

  assign AVS_READDATA = rdata_q;

endmodule : wdw_top
